/* File: logic/sfpf_pkg.sv */
// constants and types shared by the serial flash pin front end.
// assumes a system clock domain and a link domain clocked by the serial clock pin.
package sfpf_pkg;
   // lane widths of a transfer; the core sets the mode per phase
   typedef enum logic [1:0] {
      SFPF_LANE_SINGLE = 2'h0,
      SFPF_LANE_DUAL   = 2'h1,
      SFPF_LANE_QUAD   = 2'h2
   } sfpf_lane_t;

   // front end state in the system domain, one-hot
   typedef enum logic [3:0] {
      SFPF_ST_RESTART = 4'h1,
      SFPF_ST_STANDBY = 4'h2,
      SFPF_ST_ACTIVE  = 4'h4,
      SFPF_ST_PAUSED  = 4'h8
   } sfpf_state_t;

   localparam int         SFPF_BYTE_W         = 8;
   localparam logic [2:0] SFPF_LAST_EDGE_1    = 3'h7;
   localparam logic [2:0] SFPF_LAST_EDGE_2    = 3'h3;
   localparam logic [2:0] SFPF_LAST_EDGE_4    = 3'h1;
   localparam int         SFPF_SYNC_W         = 5;
   localparam logic       SFPF_DEDICATED_DFLT = 1'b0;
   localparam logic       SFPF_FUNC_BIT0_RST  = 1'b0;
   localparam logic [7:0] SFPF_RX_RST         = 8'h00;
   localparam logic [2:0] SFPF_CNT_RST        = 3'h0;
endpackage

/* File: logic/sfpf_sync.sv */
// two flip-flop level synchroniser, one bit lane per input.
// assumes each input is a slowly changing level or a toggle from another domain.
`timescale 1ns/1ps
module sfpf_sync
   import sfpf_pkg::*;
#(
   parameter int W = SFPF_SYNC_W
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage is read by the second stage only
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule // sfpf_sync

/* File: logic/sfpf_frontend.sv */
// pin front end of a serial flash: select, pause, restart, lane reuse, status write guard.
// assumes the core holds TX_BYTE, TX_EN and LANE_MODE stable while the link clock runs,
// and sets QUAD_EN, PIN_FUNC_SEL only while deselected.
//
// Overview of operation
// - shared line 3 pause or restart by select
// - select bit zero means pause function
// - dedicated variant: line 3 only pause
// - dedicated variant: function bit0 zero, pin independent
// - chip select high: standby, outputs high impedance
// - chip select low: active, accept instructions
// - no instruction before first select falling edge
// - ignore data bits while deselected
// - single lane: sample rising, drive falling
// - dual/quad: lanes bidirectional, same edges
// - quad uses protect pin and pause pin
// - disable bit set, protect low: refuse
// - disable bit clear: status always writable
// - quad enable disables write protect
// - quad enable removes pause and line 3 restart
// - pause suspends without losing progress
// - pause while selected: output high impedance
// - pause release resumes from same point
// - restart low holds reset, outputs off
// - idle clock low or high both work; transmit drives its first bit on a falling edge, so reads need idle high
`timescale 1ns/1ps
module sfpf_frontend
   import sfpf_pkg::*;
#(
   parameter logic DEDICATED_RESTART = SFPF_DEDICATED_DFLT
) (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       SCK,
   input  wire logic       CE_N,
   input  wire logic       RESTART_N,
   input  wire logic       DATA_LINE_0_I,
   output logic            DATA_LINE_0_O,
   output logic            DATA_LINE_0_OE,
   input  wire logic       DATA_LINE_1_I,
   output logic            DATA_LINE_1_O,
   output logic            DATA_LINE_1_OE,
   input  wire logic       DATA_LINE_2_I,
   output logic            DATA_LINE_2_O,
   output logic            DATA_LINE_2_OE,
   input  wire logic       DATA_LINE_3_I,
   output logic            DATA_LINE_3_O,
   output logic            DATA_LINE_3_OE,
   input  wire logic [1:0] LANE_MODE,
   input  wire logic [7:0] TX_BYTE,
   input  wire logic       TX_EN,
   input  wire logic       QUAD_EN,
   input  wire logic       PIN_FUNC_SEL,
   input  wire logic       STATUS_WRITE_DISABLE,
   input  wire logic       STATUS_WR_REQ,
   output logic            STATUS_WR_ACCEPT,
   output logic            STATUS_WR_REFUSE,
   output logic [7:0]      RX_BYTE,
   output logic            RX_VALID,
   output logic            STANDBY,
   output logic            ACTIVE,
   output logic            PAUSED,
   output logic            RESTARTING,
   output logic            FUNC_REG_BIT0
);
   // link domain: pin-level gating
   logic       restart_ok;
   logic       pause_ok;
   logic       link_clr;
   logic       out_off;
   logic [2:0] last_edge;

   // restart source: dedicated pin, or shared line 3 when selected by the bit
   assign restart_ok = DEDICATED_RESTART ? RESTART_N
                     : (QUAD_EN | ~PIN_FUNC_SEL | DATA_LINE_3_I);
   // pause source: shared line 3 unless quad, or restart took the pin
   assign pause_ok   = QUAD_EN
                     | (~DEDICATED_RESTART & PIN_FUNC_SEL)
                     | DATA_LINE_3_I;
   // deselect or restart clears the command progress; sck may be stopped then
   assign link_clr   = CE_N | ~restart_ok;
   assign out_off    = link_clr | ~pause_ok;

   always_comb begin
      case (sfpf_lane_t'(LANE_MODE))
         SFPF_LANE_DUAL: last_edge = SFPF_LAST_EDGE_2;
         SFPF_LANE_QUAD: last_edge = SFPF_LAST_EDGE_4;
         default:        last_edge = SFPF_LAST_EDGE_1;
      endcase
   end

   // receive side, rising edges
   logic [7:0] rx_sh_q;
   logic [2:0] rx_cnt_q;
   logic [7:0] rx_hold_q;
   logic       rx_tog_q;
   logic [7:0] rx_sh_d;

   always_comb begin
      case (sfpf_lane_t'(LANE_MODE))
         SFPF_LANE_DUAL: rx_sh_d = {rx_sh_q[5:0], DATA_LINE_1_I, DATA_LINE_0_I};
         SFPF_LANE_QUAD: rx_sh_d = {rx_sh_q[3:0], DATA_LINE_3_I, DATA_LINE_2_I,
                                    DATA_LINE_1_I, DATA_LINE_0_I};
         default:        rx_sh_d = {rx_sh_q[6:0], DATA_LINE_0_I};
      endcase
   end

   // edges only matter, not idle level, so mode (0,0) and (1,1) behave alike
   always_ff @(posedge SCK or posedge link_clr) begin
      if (link_clr) begin
         rx_sh_q  <= SFPF_RX_RST;
         rx_cnt_q <= SFPF_CNT_RST;
      end else if (pause_ok) begin
         rx_sh_q  <= rx_sh_d;
         rx_cnt_q <= (rx_cnt_q == last_edge) ? SFPF_CNT_RST : rx_cnt_q + 3'h1;
      end
   end

   // completed byte waits in a holding register while a toggle crosses over
   always_ff @(posedge SCK) begin
      if (!link_clr && pause_ok && rx_cnt_q == last_edge) begin
         rx_hold_q <= rx_sh_d;
      end
   end

   // toggle needs a known start for the edge detector; sck is idle during system reset
   always_ff @(posedge SCK or posedge RST) begin
      if (RST) begin
         rx_tog_q <= 1'b0;
      end else if (!link_clr && pause_ok && rx_cnt_q == last_edge) begin
         rx_tog_q <= ~rx_tog_q;
      end
   end

   // transmit side, falling edges
   logic [7:0] tx_sh_q;
   logic [2:0] tx_cnt_q;
   logic [7:0] tx_cur;

   assign tx_cur = (tx_cnt_q == SFPF_CNT_RST) ? TX_BYTE : tx_sh_q;

   always_ff @(negedge SCK or posedge link_clr) begin
      if (link_clr) begin
         tx_sh_q  <= SFPF_RX_RST;
         tx_cnt_q <= SFPF_CNT_RST;
      end else if (pause_ok) begin
         tx_cnt_q <= (tx_cnt_q == last_edge) ? SFPF_CNT_RST : tx_cnt_q + 3'h1;
         case (sfpf_lane_t'(LANE_MODE))
            SFPF_LANE_DUAL: tx_sh_q <= {tx_cur[5:0], 2'h0};
            SFPF_LANE_QUAD: tx_sh_q <= {tx_cur[3:0], 4'h0};
            default:        tx_sh_q <= {tx_cur[6:0], 1'h0};
         endcase
      end
   end

   always_ff @(negedge SCK) begin
      if (pause_ok) begin
         case (sfpf_lane_t'(LANE_MODE))
            SFPF_LANE_DUAL: begin
               DATA_LINE_1_O <= tx_cur[7];
               DATA_LINE_0_O <= tx_cur[6];
            end
            SFPF_LANE_QUAD: begin
               DATA_LINE_3_O <= tx_cur[7];
               DATA_LINE_2_O <= tx_cur[6];
               DATA_LINE_1_O <= tx_cur[5];
               DATA_LINE_0_O <= tx_cur[4];
            end
            default: DATA_LINE_1_O <= tx_cur[7];
         endcase
      end
   end

   // enables drop at once on deselect, pause or restart, not at the next edge
   always_ff @(negedge SCK or posedge out_off) begin
      if (out_off) begin
         DATA_LINE_0_OE <= 1'b0;
         DATA_LINE_1_OE <= 1'b0;
         DATA_LINE_2_OE <= 1'b0;
         DATA_LINE_3_OE <= 1'b0;
      end else begin
         DATA_LINE_0_OE <= TX_EN && LANE_MODE != SFPF_LANE_SINGLE;
         DATA_LINE_1_OE <= TX_EN;
         DATA_LINE_2_OE <= TX_EN && LANE_MODE == SFPF_LANE_QUAD;
         DATA_LINE_3_OE <= TX_EN && LANE_MODE == SFPF_LANE_QUAD;
      end
   end

   // system domain
   logic [SFPF_SYNC_W-1:0] sync_q;
   logic                   ce_n_s;
   logic                   restart_n_s;
   logic                   line3_s;
   logic                   line2_s;
   logic                   rx_tog_s;

   sfpf_sync #(
      .W (SFPF_SYNC_W)
   ) u_sync (
      .clk (CLK),
      .d   ({CE_N, RESTART_N, DATA_LINE_3_I, DATA_LINE_2_I, rx_tog_q}),
      .q   (sync_q)
   );

   assign {ce_n_s, restart_n_s, line3_s, line2_s, rx_tog_s} = sync_q;

   logic restart_ok_s;
   logic pause_ok_s;
   assign restart_ok_s = DEDICATED_RESTART ? restart_n_s
                       : (QUAD_EN | ~PIN_FUNC_SEL | line3_s);
   assign pause_ok_s   = QUAD_EN | (~DEDICATED_RESTART & PIN_FUNC_SEL) | line3_s;

   sfpf_state_t state_q;
   sfpf_state_t state_d;

   always_comb begin
      if (!restart_ok_s) begin
         state_d = SFPF_ST_RESTART;
      end else if (ce_n_s) begin
         state_d = SFPF_ST_STANDBY;
      end else if (!pause_ok_s) begin
         state_d = SFPF_ST_PAUSED;
      end else begin
         state_d = SFPF_ST_ACTIVE;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_q <= SFPF_ST_STANDBY;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         STANDBY    <= 1'b1;
         ACTIVE     <= 1'b0;
         PAUSED     <= 1'b0;
         RESTARTING <= 1'b0;
      end else begin
         STANDBY    <= state_d == SFPF_ST_STANDBY;
         ACTIVE     <= state_d == SFPF_ST_ACTIVE;
         PAUSED     <= state_d == SFPF_ST_PAUSED;
         RESTARTING <= state_d == SFPF_ST_RESTART;
      end
   end

   // armed only after chip select has been seen high since reset
   logic armed_q;
   logic frame_ok_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         armed_q <= 1'b0;
      end else if (ce_n_s && restart_ok_s) begin
         armed_q <= 1'b1;
      end
   end

   // held until the next frame or a restart so a late byte of this frame is still judged by it
   always_ff @(posedge CLK) begin
      if (RST) begin
         frame_ok_q <= 1'b0;
      end else if (state_q == SFPF_ST_STANDBY && state_d == SFPF_ST_ACTIVE) begin
         frame_ok_q <= armed_q;
      end else if (state_d == SFPF_ST_RESTART) begin
         frame_ok_q <= 1'b0;
      end
   end

   logic rx_tog_d1_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         rx_tog_d1_q <= 1'b0;
         RX_VALID    <= 1'b0;
         RX_BYTE     <= SFPF_RX_RST;
      end else begin
         rx_tog_d1_q <= rx_tog_s;
         RX_VALID    <= (rx_tog_s != rx_tog_d1_q) && frame_ok_q;
         if (rx_tog_s != rx_tog_d1_q) begin
            RX_BYTE <= rx_hold_q;
         end
      end
   end

   // status write guard; the protect pin only counts while quad is off
   logic wr_locked;
   assign wr_locked = STATUS_WRITE_DISABLE && !line2_s && !QUAD_EN;

   always_ff @(posedge CLK) begin
      if (RST) begin
         STATUS_WR_ACCEPT <= 1'b0;
         STATUS_WR_REFUSE <= 1'b0;
      end else begin
         STATUS_WR_ACCEPT <= STATUS_WR_REQ && !wr_locked;
         STATUS_WR_REFUSE <= STATUS_WR_REQ && wr_locked;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         FUNC_REG_BIT0 <= SFPF_FUNC_BIT0_RST;
      end else begin
         FUNC_REG_BIT0 <= SFPF_FUNC_BIT0_RST;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   sequence s_pause_on_line3;
      !DEDICATED_RESTART && !QUAD_EN && !PIN_FUNC_SEL && !line3_s && !ce_n_s;
   endsequence

   sequence s_quad_line3_low;
      QUAD_EN && !line3_s && !ce_n_s && restart_n_s;
   endsequence

   a_restart_holds: assert property (!restart_ok_s |=> RESTARTING && !ACTIVE)
      else $error("restart input low but not in restart");
   a_standby_deselect: assert property (restart_ok_s && ce_n_s |=> STANDBY)
      else $error("deselected but not standby");
   a_pause_select: assert property (s_pause_on_line3 |=> PAUSED)
      else $error("line 3 low with select bit 0 did not pause");
   a_quad_no_pause: assert property (s_quad_line3_low ##1 s_quad_line3_low |=> ACTIVE)
      else $error("quad mode paused or restarted on line 3");
   a_wp_refuse: assert property (STATUS_WR_REQ && wr_locked
      |=> STATUS_WR_REFUSE && !STATUS_WR_ACCEPT)
      else $error("protected status write not refused");
   a_swd_open: assert property (STATUS_WR_REQ && !STATUS_WRITE_DISABLE
      |=> STATUS_WR_ACCEPT)
      else $error("unprotected status write refused");
   a_quad_wp_off: assert property (STATUS_WR_REQ && QUAD_EN |=> STATUS_WR_ACCEPT)
      else $error("quad mode still applied write protect");
   a_rx_armed: assert property (RX_VALID |-> frame_ok_q && $past(armed_q, 2))
      else $error("byte delivered before first select edge");
   a_rx_pulse: assert property (RX_VALID |=> !RX_VALID)
      else $error("byte strobe longer than one cycle");
endmodule // sfpf_frontend

/* File: verif/sfpf_master.sv */
// behavioural serial bus master facing the flash pin front end.
// assumes the bench resolves each data line from device enables and m_val.
`timescale 1ns/1ps
module sfpf_master (
   output logic       sck,
   output logic       ce_n,
   output logic [3:0] m_val,
   input  wire  [3:0] lvl
);
   logic       cpol;
   logic [7:0] rd;

   initial begin
      cpol  = 1'b0;
      sck   = 1'b0;
      m_val = 4'hC;
      rd    = 8'h00;
      // a clean rising select after time zero clears the link side
      #1;
      ce_n  = 1'b1; // select edge always precedes the first instruction
   end

   // idle clock level is fixed by the mode; clock stands still outside shift calls
   task automatic mode(input logic p);
      cpol = p;
      sck  = p;
   endtask

   // pause and write protect lines are driven high again at each deselect
   task automatic select(input logic on);
      #13;
      ce_n = !on;
      if (!on) m_val[3:2] = 2'h3;
      #13;
   endtask

   task automatic set_line(input int i, input logic b);
      m_val[i] = b;
   endtask

   // drive lanes after the falling edge, sample the device lanes at the rise
   task automatic shift(input int lanes, input int n, input logic [7:0] v);
      for (int i = 0; i < n; i++) begin
         sck = 1'b0;
         case (lanes)
            1: m_val = {m_val[3:2], ~m_val[1], v[7]};
            2: m_val = {m_val[3:2], v[7:6]};
            default: m_val = v[7:4];
         endcase
         v = v << lanes;
         #24;
         sck = 1'b1;
         case (lanes)
            1: rd = {rd[6:0], lvl[1]};
            2: rd = {rd[5:0], lvl[1:0]};
            default: rd = {rd[3:0], lvl};
         endcase
         #24;
      end
      if (!cpol) sck = 1'b0;
   endtask
endmodule // sfpf_master

/* File: verif/test_serial_flash_pin_frontend.sv */
// self-checking bench for the serial flash pin front end with a master model.
// covers the standard variant, plus the standby and restart outputs of the dedicated restart variant driven by the restart pin.
`timescale 1ns/1ps
module test_serial_flash_pin_frontend;
   import sfpf_pkg::*;
   logic       clk, rst, restart_n, tx_en, quad_en, pin_func_sel, swd, sw_req;
   logic       ded_standby, ded_restarting, ded_func_bit0;
   logic [1:0] lane_mode;
   logic [7:0] tx_byte, rx_byte, v, w, t;
   logic [1:0] e;
   logic       sw_acc, sw_ref, rx_valid, standby, active, paused, restarting, func_bit0;
   logic       sck, ce_n;
   logic [3:0] m_val;
   wire  [3:0] d_o, d_oe, lvl;
   logic [7:0] rx_q[$];
   logic [1:0] sw_q[$];
   int         errors, n_checks;

   assign lvl = (d_oe & d_o) | (~d_oe & m_val);

   sfpf_master mst (.sck(sck), .ce_n(ce_n), .m_val(m_val), .lvl(lvl));

   sfpf_frontend dut (
      .CLK(clk), .RST(rst), .SCK(sck), .CE_N(ce_n), .RESTART_N(restart_n),
      .DATA_LINE_0_I(lvl[0]), .DATA_LINE_0_O(d_o[0]), .DATA_LINE_0_OE(d_oe[0]),
      .DATA_LINE_1_I(lvl[1]), .DATA_LINE_1_O(d_o[1]), .DATA_LINE_1_OE(d_oe[1]),
      .DATA_LINE_2_I(lvl[2]), .DATA_LINE_2_O(d_o[2]), .DATA_LINE_2_OE(d_oe[2]),
      .DATA_LINE_3_I(lvl[3]), .DATA_LINE_3_O(d_o[3]), .DATA_LINE_3_OE(d_oe[3]),
      .LANE_MODE(lane_mode), .TX_BYTE(tx_byte), .TX_EN(tx_en), .QUAD_EN(quad_en),
      .PIN_FUNC_SEL(pin_func_sel), .STATUS_WRITE_DISABLE(swd), .STATUS_WR_REQ(sw_req),
      .STATUS_WR_ACCEPT(sw_acc), .STATUS_WR_REFUSE(sw_ref), .RX_BYTE(rx_byte),
      .RX_VALID(rx_valid), .STANDBY(standby), .ACTIVE(active), .PAUSED(paused),
      .RESTARTING(restarting), .FUNC_REG_BIT0(func_bit0)
   );

   // dedicated restart variant on the same pins; only its STANDBY and RESTARTING outputs and function bit0 are watched
   sfpf_frontend #(
      .DEDICATED_RESTART (1'b1)
   ) dut_ded (
      .CLK(clk), .RST(rst), .SCK(sck), .CE_N(ce_n), .RESTART_N(restart_n),
      .DATA_LINE_0_I(lvl[0]), .DATA_LINE_0_O(), .DATA_LINE_0_OE(),
      .DATA_LINE_1_I(lvl[1]), .DATA_LINE_1_O(), .DATA_LINE_1_OE(),
      .DATA_LINE_2_I(lvl[2]), .DATA_LINE_2_O(), .DATA_LINE_2_OE(),
      .DATA_LINE_3_I(lvl[3]), .DATA_LINE_3_O(), .DATA_LINE_3_OE(),
      .LANE_MODE(lane_mode), .TX_BYTE(tx_byte), .TX_EN(tx_en), .QUAD_EN(quad_en),
      .PIN_FUNC_SEL(pin_func_sel), .STATUS_WRITE_DISABLE(swd), .STATUS_WR_REQ(sw_req),
      .STATUS_WR_ACCEPT(), .STATUS_WR_REFUSE(), .RX_BYTE(), .RX_VALID(),
      .STANDBY(ded_standby), .ACTIVE(), .PAUSED(), .RESTARTING(ded_restarting),
      .FUNC_REG_BIT0(ded_func_bit0)
   );

   initial clk = 1'b0;
   always #2 clk = ~clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic clocks(input int n);
      repeat (n) @(posedge clk);
   endtask

   // configuration only moves while deselected
   task automatic cfg(input logic [1:0] lm, input logic te, input logic qe,
                      input logic pfs, input logic [7:0] tx);
      @(posedge clk);
      lane_mode    <= lm;
      tx_en        <= te;
      quad_en      <= qe;
      pin_func_sel <= pfs;
      tx_byte      <= tx;
      clocks(4);
   endtask

   task automatic byte_in(input int lanes, input logic [7:0] b);
      rx_q.push_back(b);
      mst.select(1'b1);
      mst.shift(lanes, 8 / lanes, b);
      check({14'h0000, standby, active}, 16'h0001);
      mst.select(1'b0);
      clocks(8);
      check({10'h000, standby, active, d_oe}, 16'h0020);
   endtask

   // results are matched in arrival order against the notes of the driver
   always @(negedge clk) begin
      if (rx_valid === 1'b1)
         check({8'h00, rx_byte}, rx_q.size() ? {8'h00, rx_q.pop_front()} : 16'hFFFF);
      if ((sw_acc | sw_ref) === 1'b1)
         check({14'h0, sw_acc, sw_ref},
               sw_q.size() ? {14'h0, sw_q.pop_front()} : 16'hFFFF);
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up();
   end

   initial begin
      rst = 1'b0; lane_mode = 2'h0; tx_en = 1'b0; quad_en = 1'b0; pin_func_sel = 1'b0;
      tx_byte = 8'h00; swd = 1'b0; sw_req = 1'b0; errors = 0; n_checks = 0;
      restart_n = 1'b1;
      // a clean rising reset after time zero gives the link toggle its start value
      #1 rst = 1'b1;
      void'($urandom(32'h8905));
      clocks(4);
      rst <= 1'b0;
      clocks(4);
      check({11'h000, standby, active, paused, restarting, func_bit0}, 16'h0010);
      check({15'h0000, ded_func_bit0}, 16'h0000);
      // one byte per lane width; quad also carries lines 2 and 3
      for (int k = 0; k < 3; k++) begin
         cfg(k[1:0], 1'b0, k == 2, 1'b0, 8'h00);
         v = 8'($urandom);
         byte_in(1 << k, v);
      end
      cfg(2'h0, 1'b0, 1'b0, 1'b0, 8'h00);
      v = 8'($urandom);
      mst.shift(1, 8, v);
      mst.select(1'b1);
      mst.shift(1, 3, v);
      mst.select(1'b0);
      clocks(8);
      v = 8'($urandom);
      byte_in(1, v);
      // pause in mid-byte with the read path enabled
      t = 8'($urandom);
      cfg(2'h0, 1'b1, 1'b0, 1'b0, t);
      v = 8'($urandom);
      w = 8'($urandom);
      rx_q.push_back(v);
      mst.select(1'b1);
      mst.shift(1, 4, v);
      check({13'h0000, paused, active, d_oe[1]}, 16'h0003);
      mst.set_line(3, 1'b0);
      clocks(5);
      check({13'h0000, paused, active, d_oe[1]}, 16'h0004);
      mst.shift(1, 4, w);
      mst.set_line(3, 1'b1);
      clocks(5);
      mst.shift(1, 4, v << 4);
      mst.select(1'b0);
      clocks(8);
      // read a whole byte in idle-high clock mode
      mst.mode(1'b1);
      v = 8'($urandom);
      byte_in(1, v);
      check({8'h00, mst.rd}, {8'h00, t});
      // dual and quad reads loop back into the receive path as well
      for (int k = 1; k < 3; k++) begin
         cfg(k[1:0], 1'b1, k == 2, 1'b0, t);
         byte_in(1 << k, t);
         check({8'h00, mst.rd}, {8'h00, t});
      end
      mst.mode(1'b0);
      // restart only while deselected, so no internal write is cut short
      cfg(2'h0, 1'b0, 1'b0, 1'b1, 8'h00);
      mst.set_line(3, 1'b0);
      clocks(5);
      check({10'h000, standby, restarting, d_oe}, 16'h0010);
      check({14'h0000, ded_standby, ded_restarting}, 16'h0002);
      mst.set_line(3, 1'b1);
      clocks(5);
      check({14'h0000, standby, restarting}, 16'h0002);
      // dedicated pin restarts its variant only, whatever the select bit says
      restart_n <= 1'b0;
      clocks(5);
      check({12'h000, standby, restarting, ded_standby, ded_restarting}, 16'h0009);
      restart_n <= 1'b1;
      clocks(5);
      check({14'h0000, ded_standby, ded_restarting}, 16'h0002);
      cfg(2'h0, 1'b0, 1'b1, 1'b1, 8'h00);
      mst.set_line(3, 1'b0);
      clocks(5);
      check({15'h0000, restarting}, 16'h0000);
      cfg(2'h0, 1'b0, 1'b0, 1'b0, 8'h00);
      clocks(5);
      check({14'h0000, standby, restarting}, 16'h0002);
      mst.set_line(3, 1'b1);
      // every mix of disable bit, protect level and quad enable, two requests back to back
      for (int k = 0; k < 8; k++) begin
         cfg(2'h0, 1'b0, k[2], 1'b0, 8'h00);
         mst.set_line(2, k[1]);
         swd <= k[0];
         clocks(5);
         e = (k[0] && !k[1] && !k[2]) ? 2'h1 : 2'h2;
         sw_q.push_back(e);
         sw_q.push_back(e);
         sw_req <= 1'b1;
         clocks(2);
         sw_req <= 1'b0;
         clocks(3);
      end
      mst.set_line(2, 1'b1);
      clocks(10);
      check(16'(rx_q.size() + sw_q.size()), 16'h0000);
      wrap_up();
   end
endmodule // test_serial_flash_pin_frontend
